// *** verilog/uab_regs.svh ***
/*
 Register offsets, bit positions, reset values and timing counts of the
 serial buffer/status block. Assumes an 8-bit processor I/O port.
*/
`ifndef UAB_REGS_SVH
`define UAB_REGS_SVH

`define UAB_OFF_DATA     3'h0
`define UAB_OFF_STAT_A   3'h1
`define UAB_OFF_CTRL_B   3'h2
`define UAB_OFF_CTRL_C   3'h3
`define UAB_OFF_BAUD_LO  3'h4
`define UAB_OFF_BAUD_HI  3'h5

`define UAB_A_RXC        7
`define UAB_A_TXC        6
`define UAB_A_UDRE       5
`define UAB_A_FE         4
`define UAB_A_DOR        3
`define UAB_A_UPE        2
`define UAB_A_U2X        1
`define UAB_A_MPCM       0

`define UAB_B_RXCIE      7
`define UAB_B_TXCIE      6
`define UAB_B_UDRIE      5
`define UAB_B_RXEN       4
`define UAB_B_TXEN       3
`define UAB_B_SIZE2      2
`define UAB_B_RXB8       1
`define UAB_B_TXB8       0

`define UAB_C_PAR_ON     5
`define UAB_C_PAR_ODD    4
`define UAB_C_TWO_STOP   3

`define UAB_CTRL_B_RST   8'h00
`define UAB_CTRL_C_RST   8'h06
`define UAB_BAUD_RST     12'h000

`define UAB_SPB_NORMAL   5'h10
`define UAB_SPB_DOUBLE   5'h08
`define UAB_VOTE_NORMAL  5'h08
`define UAB_VOTE_DOUBLE  5'h04

`endif

// *** verilog/uab_pkg.sv ***
/*
 Types of the serial buffer/status block: states, FIFO entry, host request.
 Assumes the constants header is included by the design files.
*/
package uab_pkg;

	typedef enum logic [3:0] {
		TX_IDLE  = 4'h1,
		TX_START = 4'h2,
		TX_BITS  = 4'h4,
		TX_STOP  = 4'h8
	} uab_tx_state_e;

	typedef enum logic [3:0] {
		RX_IDLE  = 4'h1,
		RX_START = 4'h2,
		RX_BITS  = 4'h4,
		RX_STOP  = 4'h8
	} uab_rx_state_e;

	typedef struct packed {
		logic       ninth;
		logic       fe;
		logic       pe;
		logic [7:0] data;
	} uab_rx_entry_s;

	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [2:0] addr;
		logic [7:0] wdata;
	} uab_host_req_s;

endpackage : uab_pkg

// *** verilog/uab_rx_fifo.sv ***
/*
 Two-entry receive FIFO; the head comes straight out of a register.
 Assumes the caller never pushes into a full FIFO unless it pops too.
*/
`timescale 1ns/1ps

module uab_rx_fifo (
	input  wire logic          clock,
	input  wire logic          rst_n,
	input  wire logic          flush,
	input  wire logic          push,
	input  uab_pkg::uab_rx_entry_s push_data,
	input  wire logic          pop,
	output uab_pkg::uab_rx_entry_s head,
	output logic [1:0]         count
);
	uab_pkg::uab_rx_entry_s slot0_reg;
	uab_pkg::uab_rx_entry_s slot1_reg;
	uab_pkg::uab_rx_entry_s slot0_next;
	uab_pkg::uab_rx_entry_s slot1_next;
	logic [1:0]             count_reg;
	logic [1:0]             count_next;
	wire                    do_pop = pop && (count_reg != 2'h0);

	// shift structure: slot0 is always the head
	always_comb
	begin
		slot0_next = do_pop ? slot1_reg : slot0_reg;
		slot1_next = slot1_reg;
		count_next = count_reg - {1'b0, do_pop};
		if (push)
		begin
			if (count_next == 2'h0)
				slot0_next = push_data;
			else
				slot1_next = push_data;
			count_next = count_next + 2'h1;
		end
		if (flush)
			count_next = 2'h0;
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			slot0_reg <= '0;
			slot1_reg <= '0;
			count_reg <= 2'h0;
		end
		else
		begin
			slot0_reg <= slot0_next;
			slot1_reg <= slot1_next;
			count_reg <= count_next;
		end
	end

	assign head  = slot0_reg;
	assign count = count_reg;

endmodule : uab_rx_fifo

// *** verilog/uab_top.sv ***
/*
 Serial transceiver buffers, status and address-filtered reception.
 Assumes a synchronous 8-bit I/O port (one rd or wr per cycle) and a
 serial input already synchronous to clock.
*/
// Summary of operation
// - filter mode discards data frames
// - type bit: stop bit, or ninth bit
// - type one is address, zero data
// - transmitter ignores filter mode bit
// - accepted address sets receive complete normally
// - one data location for both buffers
// - short characters: upper bits ignored, zero
// - write while buffer full is discarded
// - buffer moves to shifter when empty
// - two-entry FIFO advances on each data read
// - receive complete tracks FIFO; disable flushes
// - transmit complete sets; clears by ack/one
// - buffer empty flag, one after reset
// - frame error of head character
// - overrun on start with everything full
// - parity error of head, if checked
// - double speed halves asynchronous divider
// - receive interrupt needs enable, global, flag
// - receiver disable flushes FIFO and flags
`timescale 1ns/1ps
`include "uab_regs.svh"

module uab_top (
	input  wire logic             clock,
	input  wire logic             rst_n,
	input  uab_pkg::uab_host_req_s host_req,
	input  wire logic             global_irq_en,
	input  wire logic             txc_irq_ack,
	input  wire logic             serial_in_pin,
	output logic [7:0]            host_rdata,
	output logic                  serial_out_pin,
	output logic                  rx_irq,
	output logic                  tx_irq,
	output logic                  udre_irq
);
	function automatic logic [3:0] char_len(input logic [2:0] sel);
		unique case (sel)
			3'h0:    char_len = 4'h5;
			3'h1:    char_len = 4'h6;
			3'h2:    char_len = 4'h7;
			3'h7:    char_len = 4'h9;
			default: char_len = 4'h8;
		endcase
	endfunction : char_len

	function automatic logic [8:0] char_mask(input logic [3:0] n);
		char_mask = 9'h1FF >> (4'h9 - n);
	endfunction : char_mask

	uab_pkg::uab_tx_state_e tx_state_reg, tx_state_next;
	uab_pkg::uab_rx_state_e rx_state_reg, rx_state_next;
	uab_pkg::uab_rx_entry_s head, pend_reg, pend_next, rx_entry;
	logic [7:0]  ctrl_b_reg, ctrl_c_reg, rdata_reg, rdata_next;
	logic [11:0] baud_reg, baud_cnt_reg;
	logic        u2x_reg, mpcm_reg, txc_reg, txc_next, dor_reg, dor_next;
	logic [8:0]  tx_buf_reg;
	logic        tx_buf_valid_reg, tx_buf_valid_next;
	logic [9:0]  tx_shift_reg, tx_shift_next;
	logic [3:0]  tx_cnt_reg, tx_cnt_next;
	logic [4:0]  tx_samp_reg;
	logic        tx_out_reg, tx_out_next, tx_done;
	logic [4:0]  rx_samp_reg, rx_samp_next;
	logic [1:0]  rx_ones_reg, rx_ones_next, fifo_count;
	logic [9:0]  rx_shift_reg, rx_shift_next;
	logic [3:0]  rx_cnt_reg, rx_cnt_next;
	logic        rx_prev_reg, pend_valid_reg, pend_valid_next, rx_done;
	logic        rx_irq_reg, tx_irq_reg, udre_irq_reg;

	// host port decode
	wire sel_data  = host_req.addr == `UAB_OFF_DATA;
	wire sel_stat  = host_req.addr == `UAB_OFF_STAT_A;
	wire rd_data   = host_req.rd && sel_data;
	wire wr_data   = host_req.wr && sel_data;
	wire wr_stat   = host_req.wr && sel_stat;
	wire wr_ctrl_b = host_req.wr && host_req.addr == `UAB_OFF_CTRL_B;
	wire wr_ctrl_c = host_req.wr && host_req.addr == `UAB_OFF_CTRL_C;
	wire wr_b_lo   = host_req.wr && host_req.addr == `UAB_OFF_BAUD_LO;
	wire wr_b_hi   = host_req.wr && host_req.addr == `UAB_OFF_BAUD_HI;

	// shared frame format
	wire       rxen      = ctrl_b_reg[`UAB_B_RXEN];
	wire       txen      = ctrl_b_reg[`UAB_B_TXEN];
	wire [3:0] nbits     = char_len({ctrl_b_reg[`UAB_B_SIZE2], ctrl_c_reg[2:1]});
	wire [8:0] cmask     = char_mask(nbits);
	wire       par_on    = ctrl_c_reg[`UAB_C_PAR_ON];
	wire       par_odd   = ctrl_c_reg[`UAB_C_PAR_ODD];
	wire [3:0] frame_len = nbits + {3'h0, par_on};
	wire       async_md  = ctrl_c_reg[7:6] == 2'h0;
	// synchronous mode is not built here, so double speed is gated off
	wire       dbl       = u2x_reg && async_md;
	wire [4:0] spb       = dbl ? `UAB_SPB_DOUBLE : `UAB_SPB_NORMAL;
	wire [4:0] vote_f    = dbl ? `UAB_VOTE_DOUBLE : `UAB_VOTE_NORMAL;
	wire       tick      = baud_cnt_reg == 12'h000;

	// status view
	wire       fifo_nempty = fifo_count != 2'h0;
	wire       rxc   = fifo_nempty;
	wire       udre  = !tx_buf_valid_reg;
	wire       fe_q  = head.fe && fifo_nempty;
	wire       upe_q = head.pe && fifo_nempty;
	wire [7:0] stat_a = {rxc, txc_reg, udre, fe_q, dor_reg, upe_q, u2x_reg, mpcm_reg};
	wire [7:0] ctrl_b_rd = {ctrl_b_reg[7:2], head.ninth, ctrl_b_reg[0]};

	always_comb
	begin
		rdata_next = rdata_reg;
		if (host_req.rd)
		begin
			unique case (host_req.addr)
				`UAB_OFF_DATA:    rdata_next = head.data & {8{fifo_nempty}};
				`UAB_OFF_STAT_A:  rdata_next = stat_a;
				`UAB_OFF_CTRL_B:  rdata_next = ctrl_b_rd;
				`UAB_OFF_CTRL_C:  rdata_next = ctrl_c_reg;
				`UAB_OFF_BAUD_LO: rdata_next = baud_reg[7:0];
				`UAB_OFF_BAUD_HI: rdata_next = {4'h0, baud_reg[11:8]};
				default:          rdata_next = 8'h00;
			endcase
		end
	end

	// transmitter; the filter bit is never looked at here
	wire       tx_load  = tx_state_reg == uab_pkg::TX_IDLE && tx_buf_valid_reg && txen;
	wire       tx_bend  = tick && tx_samp_reg == spb - 5'h01;
	wire [8:0] tx_data  = tx_buf_reg & cmask;
	wire       tx_par   = ^tx_data ^ par_odd;
	wire [9:0] tx_frame = {1'b0, tx_data} | ({9'h000, tx_par && par_on} << nbits);

	always_comb
	begin
		tx_state_next = tx_state_reg;
		tx_shift_next = tx_shift_reg;
		tx_cnt_next   = tx_cnt_reg;
		tx_out_next   = 1'b1;
		tx_done       = 1'b0;
		unique case (tx_state_reg)
			uab_pkg::TX_IDLE:
				if (tx_load)
				begin
					tx_state_next = uab_pkg::TX_START;
					tx_shift_next = tx_frame;
					tx_cnt_next   = frame_len;
					tx_out_next   = 1'b0;
				end
			uab_pkg::TX_START:
			begin
				tx_out_next = 1'b0;
				if (tx_bend)
				begin
					tx_state_next = uab_pkg::TX_BITS;
					tx_out_next   = tx_shift_reg[0];
				end
			end
			uab_pkg::TX_BITS:
			begin
				tx_out_next = tx_shift_reg[0];
				if (tx_bend)
				begin
					tx_shift_next = tx_shift_reg >> 1;
					tx_cnt_next   = tx_cnt_reg - 4'h1;
					tx_out_next   = tx_shift_reg[1];
					if (tx_cnt_reg == 4'h1)
					begin
						tx_state_next = uab_pkg::TX_STOP;
						tx_cnt_next   = ctrl_c_reg[`UAB_C_TWO_STOP] ? 4'h2 : 4'h1;
						tx_out_next   = 1'b1;
					end
				end
			end
			uab_pkg::TX_STOP:
				if (tx_bend)
				begin
					tx_cnt_next = tx_cnt_reg - 4'h1;
					if (tx_cnt_reg == 4'h1)
					begin
						tx_state_next = uab_pkg::TX_IDLE;
						tx_done       = 1'b1;
					end
				end
		endcase
	end

	// a write while the buffer is occupied leaves it untouched
	assign tx_buf_valid_next = (tx_buf_valid_reg && !tx_load) || (wr_data && udre);
	assign txc_next = (tx_done && !tx_buf_valid_reg) ||
		(txc_reg && !txc_irq_ack && !(wr_stat && host_req.wdata[`UAB_A_TXC]));

	// receiver: three-sample majority around the bit centre
	wire [4:0] rx_vl   = vote_f + 5'h02;
	wire       rx_vote = rx_samp_reg >= vote_f && rx_samp_reg <= rx_vl;
	wire [1:0] rx_sum  = rx_ones_reg + {1'b0, serial_in_pin};
	wire       rx_maj  = rx_sum >= 2'h2;
	wire       rx_dec  = tick && rx_samp_reg == rx_vl;
	wire       rx_fall = tick && rx_prev_reg && !serial_in_pin;
	wire       rx_go   = rx_state_reg == uab_pkg::RX_IDLE && rx_fall && rxen;
	wire       fifo_full = fifo_count == 2'h2;
	wire       ovr_set = rx_go && pend_valid_reg && fifo_full;

	always_comb
	begin
		rx_state_next = rx_state_reg;
		rx_samp_next  = rx_samp_reg;
		rx_ones_next  = rx_ones_reg;
		rx_shift_next = rx_shift_reg;
		rx_cnt_next   = rx_cnt_reg;
		rx_done       = 1'b0;
		if (rx_go)
		begin
			rx_state_next = uab_pkg::RX_START;
			rx_samp_next  = 5'h01;
			rx_ones_next  = 2'h0;
		end
		else if (tick && rx_state_reg != uab_pkg::RX_IDLE)
		begin
			rx_samp_next = (rx_samp_reg == spb) ? 5'h01 : rx_samp_reg + 5'h01;
			if (rx_vote)
				rx_ones_next = rx_sum;
			if (rx_samp_reg == spb)
				rx_ones_next = 2'h0;
			unique case (rx_state_reg)
				uab_pkg::RX_START:
					if (rx_dec && rx_maj)
						rx_state_next = uab_pkg::RX_IDLE;
					else if (rx_samp_reg == spb)
					begin
						rx_state_next = uab_pkg::RX_BITS;
						rx_cnt_next   = frame_len;
					end
				uab_pkg::RX_BITS:
					if (rx_dec)
					begin
						rx_shift_next = {rx_maj, rx_shift_reg[9:1]};
						rx_cnt_next   = rx_cnt_reg - 4'h1;
					end
					else if (rx_samp_reg == spb && rx_cnt_reg == 4'h0)
						rx_state_next = uab_pkg::RX_STOP;
				uab_pkg::RX_STOP:
					if (rx_dec)
					begin
						rx_state_next = uab_pkg::RX_IDLE;
						rx_done       = 1'b1;
					end
				default:
					rx_state_next = uab_pkg::RX_IDLE;
			endcase
		end
		if (!rxen)
			rx_state_next = uab_pkg::RX_IDLE;
	end

	// frame assembly; status travels with its character
	wire [9:0] rx_algn  = rx_shift_reg >> (4'hA - frame_len);
	wire [8:0] rx_data  = rx_algn[8:0] & cmask;
	wire       rx_pbit  = rx_algn[nbits];
	wire       rx_type  = (nbits == 4'h9) ? rx_data[8] : rx_maj;
	// one marks an address frame, zero a data frame
	wire       rx_keep  = !(mpcm_reg && !rx_type);
	wire       drain    = pend_valid_reg && (!fifo_full || rd_data);
	assign rx_entry.ninth = rx_data[8];
	assign rx_entry.fe    = !rx_maj;
	assign rx_entry.pe    = par_on && ((^rx_data ^ par_odd) != rx_pbit);
	assign rx_entry.data  = rx_data[7:0];

	// a held character is kept; a later one that finds no room is lost
	always_comb
	begin
		pend_next       = pend_reg;
		pend_valid_next = pend_valid_reg && !drain;
		if (rx_done && rx_keep && !pend_valid_next)
		begin
			pend_next       = rx_entry;
			pend_valid_next = 1'b1;
		end
		if (!rxen)
			pend_valid_next = 1'b0;
	end

	// overrun set wins over the clearing read
	assign dor_next = rxen && (ovr_set || (dor_reg && !rd_data));

	uab_rx_fifo u_fifo (
		.clock     (clock),
		.rst_n     (rst_n),
		.flush     (!rxen),
		.push      (drain),
		.push_data (pend_reg),
		.pop       (rd_data),
		.head      (head),
		.count     (fifo_count)
	);

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ctrl_b_reg <= `UAB_CTRL_B_RST;
			ctrl_c_reg <= `UAB_CTRL_C_RST;
			baud_reg   <= `UAB_BAUD_RST;
			u2x_reg    <= 1'b0;
			mpcm_reg   <= 1'b0;
		end
		else
		begin
			if (wr_ctrl_b)
				ctrl_b_reg <= host_req.wdata;
			if (wr_ctrl_c)
				ctrl_c_reg <= host_req.wdata;
			if (wr_b_lo)
				baud_reg[7:0] <= host_req.wdata;
			if (wr_b_hi)
				baud_reg[11:8] <= host_req.wdata[3:0];
			if (wr_stat)
			begin
				u2x_reg  <= host_req.wdata[`UAB_A_U2X];
				mpcm_reg <= host_req.wdata[`UAB_A_MPCM];
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			baud_cnt_reg <= `UAB_BAUD_RST;
			tx_samp_reg  <= 5'h00;
			rx_prev_reg  <= 1'b1;
		end
		else
		begin
			// a low-byte write restarts the prescaler at once
			if (wr_b_lo)
				baud_cnt_reg <= {baud_reg[11:8], host_req.wdata};
			else
				baud_cnt_reg <= tick ? baud_reg : baud_cnt_reg - 12'h001;
			if (tx_load || tx_bend)
				tx_samp_reg <= 5'h00;
			else if (tick)
				tx_samp_reg <= tx_samp_reg + 5'h01;
			if (tick)
				rx_prev_reg <= serial_in_pin;
		end
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tx_state_reg     <= uab_pkg::TX_IDLE;
			tx_shift_reg     <= 10'h000;
			tx_cnt_reg       <= 4'h0;
			tx_out_reg       <= 1'b1;
			tx_buf_reg       <= 9'h000;
			tx_buf_valid_reg <= 1'b0;
			txc_reg          <= 1'b0;
		end
		else
		begin
			tx_state_reg     <= tx_state_next;
			tx_shift_reg     <= tx_shift_next;
			tx_cnt_reg       <= tx_cnt_next;
			tx_out_reg       <= tx_out_next;
			tx_buf_valid_reg <= tx_buf_valid_next;
			txc_reg          <= txc_next;
			if (wr_data && udre)
				tx_buf_reg <= {ctrl_b_reg[`UAB_B_TXB8], host_req.wdata};
		end
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rx_state_reg   <= uab_pkg::RX_IDLE;
			rx_samp_reg    <= 5'h00;
			rx_ones_reg    <= 2'h0;
			rx_shift_reg   <= 10'h000;
			rx_cnt_reg     <= 4'h0;
			pend_reg       <= '0;
			pend_valid_reg <= 1'b0;
			dor_reg        <= 1'b0;
		end
		else
		begin
			rx_state_reg   <= rx_state_next;
			rx_samp_reg    <= rx_samp_next;
			rx_ones_reg    <= rx_ones_next;
			rx_shift_reg   <= rx_shift_next;
			rx_cnt_reg     <= rx_cnt_next;
			pend_reg       <= pend_next;
			pend_valid_reg <= pend_valid_next;
			dor_reg        <= dor_next;
		end
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rdata_reg    <= 8'h00;
			rx_irq_reg   <= 1'b0;
			tx_irq_reg   <= 1'b0;
			udre_irq_reg <= 1'b0;
		end
		else
		begin
			rdata_reg    <= rdata_next;
			rx_irq_reg   <= ctrl_b_reg[`UAB_B_RXCIE] && global_irq_en && rxc;
			tx_irq_reg   <= ctrl_b_reg[`UAB_B_TXCIE] && global_irq_en && txc_reg;
			udre_irq_reg <= ctrl_b_reg[`UAB_B_UDRIE] && global_irq_en && udre;
		end
	end

	assign host_rdata     = rdata_reg;
	assign serial_out_pin = tx_out_reg;
	assign rx_irq         = rx_irq_reg;
	assign tx_irq         = tx_irq_reg;
	assign udre_irq       = udre_irq_reg;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	filter_drop_a: assert property (rx_done && mpcm_reg && !rx_type && !pend_valid_reg
		|=> !pend_valid_reg) else $error("data frame kept in filter mode");
	addr_kept_a: assert property (rx_done && rx_type && rxen && !pend_valid_reg
		|=> pend_valid_reg) else $error("address frame not kept");
	full_write_a: assert property (wr_data && !udre
		|=> $stable(tx_buf_reg)) else $error("write into full buffer");
	empty_flag_a: assert property (wr_data && udre && !tx_load
		|=> !stat_a[`UAB_A_UDRE] ##0 tx_buf_valid_reg) else $error("buffer empty flag");
	txc_set_a: assert property (tx_done && !tx_buf_valid_reg
		|=> txc_reg) else $error("transmit complete not set");
	flush_a: assert property ($fell(rxen) |-> ##1 fifo_count == 2'h0 && !dor_reg)
		else $error("receiver disable did not flush");
	overrun_a: assert property (ovr_set |=> dor_reg)
		else $error("overrun not flagged");
	pop_count_a: assert property (rd_data && fifo_nempty && !drain && rxen
		|=> fifo_count == $past(fifo_count) - 2'h1) else $error("read did not pop");
	rx_irq_a: assert property (rx_irq
		|-> $past(ctrl_b_reg[`UAB_B_RXCIE] && global_irq_en && rxc)) else $error("bad rx irq");
	tx_idle_a: assert property (tx_state_reg == uab_pkg::TX_IDLE && !tx_load
		|=> serial_out_pin) else $error("line not idle high");

	addr_frame_c: cover property (rx_done && mpcm_reg && rx_type);
	overrun_c: cover property (ovr_set);
	txc_c: cover property (tx_done && !tx_buf_valid_reg);
	pop_two_c: cover property (rd_data && fifo_full);

endmodule : uab_top

// *** verif/uab_peer.sv ***
/*
 Far-end serial port of another controller on the shared line.
 Assumes baud register 0: 16 clocks per bit, or 8 at double speed.
*/
`timescale 1ns/1ps

module uab_peer (
	input  wire logic clock,
	output logic      peer_tx,
	input  wire logic peer_rx
);
	logic [7:0] got_q [$];
	int         bit_clks = 16;

	initial peer_tx = 1'b1;

	// start, n data bits lsb first, first stop as given, second stop high
	task automatic send(input logic [8:0] d, input int n, input logic stop1);
		for (int i = -1; i <= n + 1; i++)
		begin
			peer_tx = (i < 0) ? 1'b0 : (i < n) ? d[i] : (i == n) ? stop1 : 1'b1;
			repeat (bit_clks) @(negedge clock);
		end
	endtask : send

	// 8-bit capture; a frame with a low stop bit is not kept
	always
	begin : mon
		logic [7:0] b;
		@(negedge peer_rx);
		repeat (bit_clks / 2) @(posedge clock);
		for (int i = 0; i < 8; i++)
		begin
			repeat (bit_clks) @(posedge clock);
			b[i] = peer_rx;
		end
		repeat (bit_clks) @(posedge clock);
		if (peer_rx)
			got_q.push_back(b);
	end
endmodule : uab_peer

// *** verif/tb_top.sv ***
/*
 Self-checking bench of the serial buffer/status block.
 Assumes the register offsets and bits of the constants header, baud 0.
*/
`timescale 1ns/1ps
`include "uab_regs.svh"

module tb_top;
	logic                   clock;
	logic                   rst_n;
	uab_pkg::uab_host_req_s host_req;
	logic                   global_irq_en;
	logic                   serial_in_pin;
	logic [7:0]             host_rdata;
	logic                   serial_out_pin;
	logic                   rx_irq;
	logic                   tx_irq;
	logic                   udre_irq;
	logic                   txc_irq_ack;
	int                     err_total;
	int                     samples_checked;

	uab_top uut (
		.clock          (clock),
		.rst_n          (rst_n),
		.host_req       (host_req),
		.global_irq_en  (global_irq_en),
		.txc_irq_ack    (txc_irq_ack),
		.serial_in_pin  (serial_in_pin),
		.host_rdata     (host_rdata),
		.serial_out_pin (serial_out_pin),
		.rx_irq         (rx_irq),
		.tx_irq         (tx_irq),
		.udre_irq       (udre_irq)
	);

	uab_peer peer (
		.clock   (clock),
		.peer_tx (serial_in_pin),
		.peer_rx (serial_out_pin)
	);

	initial
	begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end

	task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			$display("Error %s expected %h seen %h", name, exp, got);
			err_total++;
		end
	endtask : chk

	task wr(input logic [2:0] a, input logic [7:0] d);
		@(negedge clock);
		host_req = '{1'b0, 1'b1, a, d};
		@(negedge clock);
		host_req.wr = 1'b0;
	endtask : wr

	// two data writes on consecutive edges
	task wr_pair(input logic [7:0] d1, input logic [7:0] d2);
		@(negedge clock);
		host_req = '{1'b0, 1'b1, `UAB_OFF_DATA, d1};
		@(negedge clock);
		host_req.wdata = d2;
		@(negedge clock);
		host_req.wr = 1'b0;
	endtask : wr_pair

	task rdc(input logic [2:0] a, input logic [7:0] exp, input string name);
		@(negedge clock);
		host_req = '{1'b1, 1'b0, a, 8'h00};
		@(negedge clock);
		host_req.rd = 1'b0;
		chk(name, exp, host_rdata);
	endtask : rdc

	task final_report;
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : final_report

	// whole run is near 2400 cycles
	initial
	begin
		#1000000;
		err_total++;
		final_report;
	end

	initial
	begin
		host_req = '0;
		global_irq_en = 1'b1;
		txc_irq_ack = 1'b0;
		err_total = 0;
		samples_checked = 0;
		rst_n = 1'b0;
		repeat (8) @(negedge clock);
		rst_n = 1'b1;
		rdc(`UAB_OFF_STAT_A, 8'h20, "status");
		rdc(`UAB_OFF_CTRL_B, 8'h00, "control b");
		rdc(3'h6, 8'h00, "unmapped");
		$display("test reset done");

		// transmit with filter mode on; second write of each pair is dropped
		wr(`UAB_OFF_STAT_A, 8'h01);
		wr(`UAB_OFF_CTRL_B, 8'h28);
		wr_pair(8'hA5, 8'h3C);
		wr_pair(8'h5A, 8'hFF);
		chk("udre irq", 8'h00, {7'h00, udre_irq});
		for (int k = 0; k < 1000 && peer.got_q.size() < 2; k++)
			@(negedge clock);
		repeat (20) @(negedge clock);
		chk("udre irq", 8'h01, {7'h00, udre_irq});
		chk("tx count", 8'h02, 8'(peer.got_q.size()));
		chk("tx first", 8'hA5, peer.got_q[0]);
		chk("tx second", 8'h5A, peer.got_q[1]);
		rdc(`UAB_OFF_STAT_A, 8'h61, "status");
		wr(`UAB_OFF_STAT_A, 8'h41);
		$display("test transmit done");

		// 9-bit reception with address filter
		wr(`UAB_OFF_CTRL_B, 8'h94);
		peer.send(9'h011, 9, 1'b1);
		rdc(`UAB_OFF_STAT_A, 8'h21, "status");
		peer.send(9'h142, 9, 1'b1);
		rdc(`UAB_OFF_STAT_A, 8'hA1, "status");
		chk("rx irq", 8'h01, {7'h00, rx_irq});
		global_irq_en = 1'b0;
		repeat (3) @(negedge clock);
		chk("rx irq", 8'h00, {7'h00, rx_irq});
		global_irq_en = 1'b1;
		rdc(`UAB_OFF_CTRL_B, 8'h96, "control b");
		rdc(`UAB_OFF_DATA, 8'h42, "data");
		wr(`UAB_OFF_STAT_A, 8'h00);
		peer.send(9'h033, 9, 1'b1);
		rdc(`UAB_OFF_CTRL_B, 8'h94, "control b");
		rdc(`UAB_OFF_DATA, 8'h33, "data");
		repeat (3) @(negedge clock);
		chk("rx irq", 8'h00, {7'h00, rx_irq});
		$display("test filter done");

		// fill fifo and hold stage, then one more start
		wr(`UAB_OFF_CTRL_B, 8'h10);
		peer.send(9'h001, 8, 1'b1);
		peer.send(9'h002, 8, 1'b0);
		peer.send(9'h003, 8, 1'b1);
		peer.send(9'h004, 8, 1'b1);
		rdc(`UAB_OFF_STAT_A, 8'hA8, "status");
		rdc(`UAB_OFF_DATA, 8'h01, "data");
		rdc(`UAB_OFF_STAT_A, 8'hB0, "status");
		rdc(`UAB_OFF_DATA, 8'h02, "data");
		rdc(`UAB_OFF_STAT_A, 8'hA0, "status");
		rdc(`UAB_OFF_DATA, 8'h03, "data");
		rdc(`UAB_OFF_STAT_A, 8'h20, "status");
		rdc(`UAB_OFF_DATA, 8'h00, "data");
		$display("test fifo done");

		// even parity, wrong parity bit on the first frame
		wr(`UAB_OFF_CTRL_C, 8'h26);
		peer.send(9'h001, 9, 1'b1);
		peer.send(9'h003, 9, 1'b1);
		rdc(`UAB_OFF_STAT_A, 8'hA4, "status");
		wr(`UAB_OFF_CTRL_B, 8'h00);
		rdc(`UAB_OFF_STAT_A, 8'h20, "status");
		wr(`UAB_OFF_CTRL_B, 8'h10);
		rdc(`UAB_OFF_DATA, 8'h00, "data");
		$display("test flush done");

		// 5-bit characters; extra ones on the line look like idle
		wr(`UAB_OFF_CTRL_C, 8'h00);
		peer.send(9'h0FF, 8, 1'b1);
		rdc(`UAB_OFF_DATA, 8'h1F, "data");
		$display("test short done");

		// double speed both ways; tx complete then cleared by the interrupt ack
		wr(`UAB_OFF_CTRL_C, 8'h06);
		wr(`UAB_OFF_STAT_A, 8'h02);
		wr(`UAB_OFF_CTRL_B, 8'h58);
		peer.bit_clks = 8;
		wr(`UAB_OFF_DATA, 8'hC3);
		peer.send(9'h096, 8, 1'b1);
		rdc(`UAB_OFF_DATA, 8'h96, "data");
		chk("tx fast", 8'hC3, peer.got_q[2]);
		chk("tx irq", 8'h01, {7'h00, tx_irq});
		txc_irq_ack = 1'b1;
		@(negedge clock);
		txc_irq_ack = 1'b0;
		rdc(`UAB_OFF_STAT_A, 8'h22, "status");
		chk("tx irq", 8'h00, {7'h00, tx_irq});
		$display("test double speed done");
		final_report;
	end
endmodule : tb_top
